// ### hw/fsi_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none
module fsi_edge_detect (
  input wire logic ref_clk, // master clock
  input wire logic reset, // sync reset, active high
  fsi_edge_if.det eIf // raw pins in, edge pulses out
);
  import fsi_pkg::*;

  typedef struct packed {
    logic [NUM_SYNC-1:0] meta;
    logic [NUM_SYNC-1:0] sync;
    logic [NUM_SYNC-1:0] prev;
    logic [NUM_SYNC-1:0] edges;
  } fsi_edge_st_t;

  fsi_edge_st_t st_q;
  fsi_edge_st_t st_d;

  // two-flop synchroniser, rising edge from second stage only
  always_comb begin
    st_d = st_q;
    st_d.meta = eIf.pins;
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;
    st_d.edges = st_q.sync & ~st_q.prev;
    if (reset) begin
      // preload with pin levels so an idle-high pin gives no false edge
      st_d = '0;
      st_d.meta = eIf.pins;
      st_d.sync = eIf.pins;
      st_d.prev = eIf.pins;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_q <= st_d;
  end

  assign eIf.edges = st_q.edges;
endmodule
`default_nettype wire

// ### hw/fsi_edge_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fsi_edge_if;
  import fsi_pkg::*;
  logic [NUM_SYNC-1:0] pins;
  logic [NUM_SYNC-1:0] edges;
  modport det (input pins, output edges);
  modport usr (output pins, input edges);
endinterface
`default_nettype wire

// ### hw/fsi_pkg.sv
package fsi_pkg;
  // clock and frame timing
  localparam int CLK_MHZ = 100;
  localparam int FRAME_PERIOD_US = 125;
  localparam int MFRAME_PERIOD_US = 500;
  localparam int FRAME_CYC = FRAME_PERIOD_US * CLK_MHZ;
  localparam int MFRAME_CYC = MFRAME_PERIOD_US * CLK_MHZ;

  // register port
  localparam int AW = 8;
  localparam int DW = 16;
  typedef logic [AW-1:0] fsi_addr_t;
  typedef logic [DW-1:0] fsi_data_t;
  localparam fsi_addr_t OFF_CTRL = 8'h00;
  localparam fsi_addr_t OFF_STATUS = 8'h04;
  localparam fsi_addr_t OFF_EXPF_FIRST = 8'h10;
  localparam fsi_addr_t OFF_EXPF_LAST = 8'h2C;
  localparam int EXPF_IDX_LSB = 2;

  // control fields
  localparam int SRC_LSB = 0;
  localparam int SRC_W = 4;
  localparam int PAIR_LSB = 4;
  localparam int PAIR_W = 2;
  localparam int FINV_BIT = 6;
  localparam int FPUL_BIT = 7;
  localparam int MINV_BIT = 8;
  localparam int MPUL_BIT = 9;
  localparam int DISC_EN_BIT = 10;
  localparam int DISC_8K_BIT = 11;
  localparam fsi_data_t CTRL_RST = 16'h0000;
  localparam logic [1:0] PAIRED_PAT = 2'h3;

  // status fields
  localparam int ST_PIN_LSB = 0;
  localparam int ST_COMP_LSB = 2;

  // input clocks, index 0..7 holds clock numbers 1,2,3,4,5,6,8,9
  localparam int NUM_CLK = 8;
  localparam int NUM_LOW_RATE = 4;
  typedef logic [3:0] fsi_clk_t;
  localparam logic [NUM_CLK-1:0][3:0] CLK_NUM =
    {4'h9, 4'h8, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
  localparam fsi_clk_t CLK_NONE = 4'h0;
  // expected frequencies in kHz
  localparam fsi_data_t EXPF_8K = 16'h0008;
  localparam fsi_data_t EXPF_19M44 = 16'h4BF0;

  // sync pins and the clock pairs they serve in paired mode
  typedef enum logic [1:0] {
    PIN_NONE = 2'h0,
    PIN_A = 2'h1,
    PIN_B = 2'h2,
    PIN_C = 2'h3
  } fsi_pin_t;
  localparam fsi_clk_t PAIR_A0 = 4'h3;
  localparam fsi_clk_t PAIR_A1 = 4'h5;
  localparam fsi_clk_t PAIR_B0 = 4'h4;
  localparam fsi_clk_t PAIR_B1 = 4'h6;
  localparam fsi_clk_t PAIR_C0 = 4'h9;
  localparam fsi_clk_t PAIR_C1 = 4'h2;
  localparam logic [1:0] PSEL_FOLLOW = 2'h0;
  localparam int NUM_SYNC = 3;
endpackage

// ### hw/fsi_sync_select.sv
// How it works
// - outside paired pattern, pin a accompanies the clock the source field names.
// - outside paired pattern, pins b and c are never used as frame sync.
// - paired pattern: pin a serves input clock 3 or 5.
// - paired pattern: pin b serves input clock 4 or 6.
// - paired pattern: pin c serves input clock 9 or 2.
// - expected frequencies reset to 8 kHz or 19.44 MHz, all writable.
// - 8 kHz and 2 kHz outputs, programmable polarity, width, optional discipline.
// - outputs reset to noninverted 50 percent duty clocks.
`timescale 1ns/10ps
`default_nettype none
module fsi_sync_select #(
  parameter int FRAME_CYCLES = fsi_pkg::FRAME_CYC,
  parameter int MFRAME_CYCLES = fsi_pkg::MFRAME_CYC
) (
  input wire logic ref_clk, // master clock
  input wire logic reset, // sync reset, active high
  input wire fsi_pkg::fsi_addr_t regAddr, // register byte address
  input wire fsi_pkg::fsi_data_t regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [fsi_pkg::DW-1:0] regRdata, // read data, cycle after strobe
  input wire logic frameSyncInA, // sync pin a
  input wire logic frameSyncInB, // sync pin b
  input wire logic frameSyncInC, // sync pin c
  input wire fsi_pkg::fsi_clk_t selectedRef, // current reference clock number
  output logic framePulseOut, // 8 kHz frame output
  output logic multiframePulseOut, // 2 kHz multiframe output
  output logic [1:0] activeSyncPin, // pin in use, 0 none
  output logic [3:0] companionClock, // clock the pin accompanies
  output logic syncApplied // pulse: frame counter realigned, multiframe counter too unless DISC_8K_BIT set
);
  import fsi_pkg::*;

  typedef struct packed {
    fsi_data_t ctrl;
    logic [NUM_CLK-1:0][DW-1:0] expf;
    logic [13:0] frameCnt;
    logic [15:0] mfCnt;
    fsi_data_t rdata;
    logic frameOut;
    logic mfOut;
    fsi_pin_t pin;
    fsi_clk_t comp;
    logic applied;
  } fsi_state_t;

  fsi_state_t st_q;
  fsi_state_t st_d;
  fsi_edge_if eIf ();

  fsi_edge_detect uEdge (
    .ref_clk(ref_clk),
    .reset(reset),
    .eIf(eIf.det)
  );

  assign eIf.pins = {frameSyncInC, frameSyncInB, frameSyncInA};

  function automatic fsi_pin_t pin_of(input fsi_clk_t c);
    if (c == PAIR_A0 || c == PAIR_A1) begin
      pin_of = PIN_A;
    end else if (c == PAIR_B0 || c == PAIR_B1) begin
      pin_of = PIN_B;
    end else if (c == PAIR_C0 || c == PAIR_C1) begin
      pin_of = PIN_C;
    end else begin
      pin_of = PIN_NONE;
    end
  endfunction

  function automatic fsi_clk_t first_of(input fsi_pin_t p);
    case (p)
      PIN_A: first_of = PAIR_A0;
      PIN_B: first_of = PAIR_B0;
      PIN_C: first_of = PAIR_C0;
      default: first_of = CLK_NONE;
    endcase
  endfunction

  logic [SRC_W-1:0] src;
  logic [PAIR_W-1:0] pairSel;
  logic paired;
  fsi_pin_t pin;
  fsi_clk_t comp;
  logic edgeSeen;
  logic apply;
  logic [2:0] expIdx;
  logic expHit;

  always_comb begin
    src = st_q.ctrl[SRC_LSB +: SRC_W];
    pairSel = st_q.ctrl[PAIR_LSB +: PAIR_W];
    paired = (src[SRC_W-1 -: 2] == PAIRED_PAT);
    pin = PIN_NONE;
    comp = CLK_NONE;
    if (!paired) begin
      // only pin a, companion named by the field
      pin = PIN_A;
      comp = src[SRC_W-1] ? CLK_NONE : CLK_NUM[src[2:0]];
    end else if (pairSel == PSEL_FOLLOW) begin
      pin = pin_of(selectedRef);
      comp = (pin == PIN_NONE) ? CLK_NONE : selectedRef;
    end else begin
      pin = fsi_pin_t'(pairSel);
      comp = (pin_of(selectedRef) == pin) ? selectedRef : first_of(pin);
    end
    case (pin)
      PIN_A: edgeSeen = eIf.edges[0];
      PIN_B: edgeSeen = eIf.edges[1];
      PIN_C: edgeSeen = eIf.edges[2];
      default: edgeSeen = 1'b0;
    endcase
    apply = edgeSeen && st_q.ctrl[DISC_EN_BIT] && comp != CLK_NONE &&
            comp == selectedRef;
  end

  always_comb begin
    expHit = (regAddr >= OFF_EXPF_FIRST) && (regAddr <= OFF_EXPF_LAST) &&
             (regAddr[1:0] == 2'h0);
    expIdx = 3'((regAddr - OFF_EXPF_FIRST) >> EXPF_IDX_LSB);
  end

  always_comb begin
    st_d = st_q;
    st_d.pin = pin;
    st_d.comp = comp;
    st_d.applied = apply;
    st_d.rdata = '0;
    // register writes
    if (regWr) begin
      if (regAddr == OFF_CTRL) begin
        st_d.ctrl = regWdata;
      end else if (expHit) begin
        st_d.expf[expIdx] = regWdata;
      end
    end
    // register reads, answer stands one cycle
    if (regRd) begin
      if (regAddr == OFF_CTRL) begin
        st_d.rdata = st_q.ctrl;
      end else if (regAddr == OFF_STATUS) begin
        st_d.rdata[ST_PIN_LSB +: 2] = st_q.pin;
        st_d.rdata[ST_COMP_LSB +: 4] = st_q.comp;
      end else if (expHit) begin
        st_d.rdata = st_q.expf[expIdx];
      end
    end
    // frame counters, realigned by the chosen sync edge, the multiframe one only while DISC_8K_BIT is clear
    if (apply) begin
      st_d.frameCnt = '0;
      if (!st_q.ctrl[DISC_8K_BIT]) begin
        st_d.mfCnt = '0;
      end else if (st_q.mfCnt == 16'(MFRAME_CYCLES - 1)) begin
        st_d.mfCnt = '0;
      end else begin
        st_d.mfCnt = st_q.mfCnt + 16'h0001;
      end
    end else begin
      if (st_q.frameCnt == 14'(FRAME_CYCLES - 1)) begin
        st_d.frameCnt = '0;
      end else begin
        st_d.frameCnt = st_q.frameCnt + 14'h0001;
      end
      if (st_q.mfCnt == 16'(MFRAME_CYCLES - 1)) begin
        st_d.mfCnt = '0;
      end else begin
        st_d.mfCnt = st_q.mfCnt + 16'h0001;
      end
    end
    // shape: 50 percent clock or one-cycle pulse, then polarity
    st_d.frameOut = st_q.ctrl[FINV_BIT] ^ (st_q.ctrl[FPUL_BIT] ?
      (st_d.frameCnt == 14'h0000) :
      (st_d.frameCnt < 14'(FRAME_CYCLES / 2)));
    st_d.mfOut = st_q.ctrl[MINV_BIT] ^ (st_q.ctrl[MPUL_BIT] ?
      (st_d.mfCnt == 16'h0000) :
      (st_d.mfCnt < 16'(MFRAME_CYCLES / 2)));
    if (reset) begin
      st_d = '0;
      st_d.ctrl = CTRL_RST;
      st_d.frameOut = 1'b1;
      st_d.mfOut = 1'b1;
      for (int i = 0; i < NUM_CLK; i++) begin
        st_d.expf[i] = (i < NUM_LOW_RATE) ? EXPF_8K : EXPF_19M44;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    st_q <= st_d;
  end

  assign regRdata = st_q.rdata;
  assign framePulseOut = st_q.frameOut;
  assign multiframePulseOut = st_q.mfOut;
  assign activeSyncPin = st_q.pin;
  assign companionClock = st_q.comp;
  assign syncApplied = st_q.applied;
endmodule
`default_nettype wire

// ### testbench/fsi_sync_pins.sv
`timescale 1ns/10ps
`default_nettype none
module fsi_sync_pins (
  input wire logic ref_clk, // master clock
  input wire logic [2:0] fire, // pulse request per pin, held while high
  output logic pinA = 1'b0, // sync pin a, rests low
  output logic pinB = 1'b0, // sync pin b, rests low
  output logic pinC = 1'b1 // sync pin c, rests high
);
  // bench holds each request only until the next one replaces it, well under a frame apart
  always @(posedge ref_clk) begin
    pinA <= fire[0];
    pinB <= fire[1];
    pinC <= ~fire[2];
  end
endmodule
`default_nettype wire

// ### testbench/fsi_sync_select_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module fsi_sync_select_asserts #(
  parameter int FRAME_CYCLES = fsi_pkg::FRAME_CYC,
  parameter int MFRAME_CYCLES = fsi_pkg::MFRAME_CYC
) (
  input wire logic ref_clk, // clock
  input wire logic reset, // reset
  input wire fsi_pkg::fsi_addr_t regAddr, // address
  input wire fsi_pkg::fsi_data_t regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  input wire logic [fsi_pkg::DW-1:0] regRdata, // read data
  input wire logic frameSyncInA, // pin a
  input wire logic frameSyncInB, // pin b
  input wire logic frameSyncInC, // pin c
  input wire fsi_pkg::fsi_clk_t selectedRef, // reference
  input wire logic framePulseOut, // frame out
  input wire logic multiframePulseOut, // multiframe out
  input wire logic [1:0] activeSyncPin, // pin in use
  input wire logic [3:0] companionClock, // companion
  input wire logic syncApplied // realign pulse
);
  import fsi_pkg::*;
  logic [3:0] pv;
  logic actPin, ctlWr, paired, pairOk;
  assign pv = {frameSyncInC, frameSyncInB, frameSyncInA, 1'b0};
  assign actPin = pv[activeSyncPin];
  assign ctlWr = regWr && regAddr == OFF_CTRL;
  assign paired = ctlWr && regWdata[3:2] == PAIRED_PAT;
  assign pairOk = (activeSyncPin == 2'h1 &&
      companionClock inside {PAIR_A0, PAIR_A1}) ||
    (activeSyncPin == 2'h2 && companionClock inside {PAIR_B0, PAIR_B1}) ||
    (activeSyncPin == 2'h3 && companionClock inside {PAIR_C0, PAIR_C1});
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_pin_rise;
    !$past(actPin, 5) && $past(actPin, 4);
  endsequence
  sequence s_src_write;
    ctlWr && regWdata[3:2] != PAIRED_PAT;
  endsequence
  a_reset_outputs: assert property (disable iff (1'b0) reset |=>
    framePulseOut && multiframePulseOut && activeSyncPin == 2'h0 &&
    companionClock == CLK_NONE && !syncApplied && regRdata == '0)
    else $error("outputs wrong after reset");
  a_applied_once: assert property (syncApplied |=> !syncApplied)
    else $error("realign pulse longer than one cycle");
  a_applied_edge: assert property (syncApplied |-> s_pin_rise)
    else $error("realign without a pin rise four cycles before");
  a_src_pin_a: assert property (s_src_write ##0 !regWdata[3] |-> ##2
    activeSyncPin == 2'h1 && companionClock == CLK_NUM[$past(regWdata[2:0], 2)])
    else $error("source field not routed to pin a");
  a_src_none: assert property (s_src_write ##0 regWdata[3] |-> ##2
    activeSyncPin == 2'h1 && companionClock == CLK_NONE)
    else $error("unused source names a companion clock");
  a_pair_force: assert property (paired && regWdata[5:4] != PSEL_FOLLOW
    |-> ##2 activeSyncPin == $past(regWdata[5:4], 2) && pairOk)
    else $error("forced pair gives wrong pin or clock");
  a_pair_follow: assert property (paired && regWdata[5:4] == PSEL_FOLLOW
    ##1 $stable(selectedRef) |-> ##1 (pairOk && companionClock == selectedRef)
    || (activeSyncPin == 2'h0 && companionClock == CLK_NONE))
    else $error("follow mode ignores the selected reference");
  a_read_idle: assert property (!regRd |=> regRdata == '0)
    else $error("read data without a read strobe");
endmodule
bind fsi_sync_select fsi_sync_select_asserts #(
  .FRAME_CYCLES(FRAME_CYCLES), .MFRAME_CYCLES(MFRAME_CYCLES)) chk (.*);
`default_nettype wire

// ### testbench/fsi_sync_select_bench.sv
`timescale 1ns/10ps
`default_nettype none
module fsi_sync_select_bench;
  import fsi_pkg::*;
  localparam int FR = 20;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  fsi_addr_t regAddr = '0;
  fsi_data_t regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [2:0] fire = 3'h0;
  fsi_clk_t selectedRef = 4'h1;
  logic [DW-1:0] regRdata;
  logic pinA, pinB, pinC, framePulseOut, multiframePulseOut, syncApplied;
  logic [1:0] activeSyncPin;
  logic [3:0] companionClock;
  int n_errors = 0;
  int n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  fsi_sync_pins far (.ref_clk(ref_clk), .fire(fire), .pinA(pinA),
    .pinB(pinB), .pinC(pinC));
  fsi_sync_select #(.FRAME_CYCLES(FR), .MFRAME_CYCLES(4 * FR)) dut (
    .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .frameSyncInA(pinA), .frameSyncInB(pinB), .frameSyncInC(pinC),
    .selectedRef(selectedRef), .framePulseOut(framePulseOut),
    .multiframePulseOut(multiframePulseOut), .activeSyncPin(activeSyncPin),
    .companionClock(companionClock), .syncApplied(syncApplied));
  task automatic stop_test;
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input fsi_addr_t a, input fsi_data_t d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input fsi_addr_t a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic t_regs;
    logic [15:0] d;
    fsi_addr_t a;
    rd(OFF_CTRL, d);
    check("ctrl", d, CTRL_RST);
    for (int i = 0; i < NUM_CLK; i++) begin
      a = OFF_EXPF_FIRST + 8'(4 * i);
      rd(a, d);
      check("expf", d, i < NUM_LOW_RATE ? EXPF_8K : EXPF_19M44);
      wr(a, 16'h00A0 + 16'(i));
      rd(a, d);
      check("expf write", d, 16'h00A0 + 16'(i));
    end
    rd(8'h08, d);
    check("unmapped", d, 16'h0000);
    rd(OFF_STATUS, d);
    check("status", d, 16'h0005);
  endtask
  task automatic t_src;
    fsi_clk_t first [4] = '{CLK_NONE, PAIR_A0, PAIR_B0, PAIR_C0};
    fsi_clk_t fol [4] = '{CLK_NONE, PAIR_A1, PAIR_B1, PAIR_C1};
    for (int s = 0; s < 12; s++) begin
      wr(OFF_CTRL, 16'(s));
      cyc(1);
      check("pin", 16'(activeSyncPin), 16'h1);
      check("comp", 16'(companionClock), s < 8 ? 16'(CLK_NUM[s & 7]) : 0);
    end
    for (int p = 1; p < 4; p++) begin
      wr(OFF_CTRL, 16'h000C | 16'(p << PAIR_LSB));
      cyc(1);
      check("pair pin", 16'(activeSyncPin), 16'(p));
      check("pair comp", 16'(companionClock), 16'(first[p]));
      @(posedge ref_clk);
      selectedRef <= fol[p];
      wr(OFF_CTRL, 16'h000C);
      cyc(1);
      check("follow pin", 16'(activeSyncPin), 16'(p));
      check("follow comp", 16'(companionClock), 16'(fol[p]));
    end
    @(posedge ref_clk);
    selectedRef <= 4'h1;
  endtask
  task automatic t_wave(input fsi_data_t ctl, input int hi, input logic lvl);
    int n;
    wr(OFF_CTRL, ctl);
    cyc(FR);
    n = 0;
    repeat (FR) begin
      cyc(1);
      if (framePulseOut === lvl) n++;
    end
    check("frame active", 16'(n), 16'(hi));
    n = 0;
    repeat (4 * FR) begin
      cyc(1);
      if (multiframePulseOut === !ctl[MINV_BIT]) n++;
    end
    check("mf active", 16'(n), ctl[MPUL_BIT] ? 16'h1 : 16'(2 * FR));
  endtask
  task automatic t_disc;
    int n;
    wr(OFF_CTRL, 16'h0C00);
    cyc(3);
    @(posedge ref_clk);
    fire <= 3'h1;
    n = 0;
    while (syncApplied !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    check("applied", 16'(syncApplied), 16'h1);
    check("realigned", 16'(framePulseOut), 16'h1);
    if (n == 8) stop_test();
    @(posedge ref_clk);
    fire <= 3'h2;
    n = 0;
    repeat (8) begin
      cyc(1);
      if (syncApplied === 1'b1) n++;
    end
    check("pin b ignored", 16'(n), 16'h0);
    fire <= 3'h0;
  endtask
  initial begin
    cyc(2);
    reset <= 1'b0;
    t_regs();
    t_src();
    t_wave(16'h0000, FR / 2, 1'b1);
    t_wave(16'h0080, 1, 1'b1);
    t_wave(16'h00C0, 1, 1'b0);
    t_wave(16'h0300, FR / 2, 1'b1);
    t_disc();
    stop_test();
  end
endmodule
`default_nettype wire
